// file: include/ddc_burst_pkg.sv
package ddc_burst_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] UPPER_THR_OFFSET = 8'h27; // Overrange upper threshold
    localparam logic [7:0] LOWER_THR_OFFSET = 8'h28; // Overrange lower threshold
    localparam logic [7:0] UPPER_THR_RESET = 8'h88; // Maximum code setting
    localparam logic [7:0] LOWER_THR_RESET = 8'h08; // Minimum code setting

    // ------------------------------------------------------------
    // Burst counts and limits
    // ------------------------------------------------------------
    localparam logic [25:0] HC_DEFAULT = 26'h0000001; // High count default
    localparam logic [7:0] LC_DEFAULT = 8'h03; // Low count default
    localparam logic [27:0] DUTY_RATIO = 28'h0000003; // Low per high
    localparam int LOW_RES_DROP = 5; // 14-bit to 9-bit

    // ------------------------------------------------------------
    // Data path constants
    // ------------------------------------------------------------
    localparam logic [15:0] QUARTER_POS = 16'h4000; // Tuning at +fs/4
    localparam logic [15:0] QUARTER_NEG = 16'hc000; // Tuning at -fs/4
    localparam logic [15:0] COS_OFFSET = 16'h4000; // Quarter turn
    localparam int LUT_SHIFT = 7; // Sine table scale

    typedef enum logic [2:0] {
        MODE_FS4_IQ, MODE_NCO_IQ, MODE_REAL_DEC4, MODE_NCO_REAL2,
        MODE_NCO_REAL4, MODE_RESERVED, MODE_NCO_DEC8, MODE_ZERO_STUFF
    } ddc_mode_e;

    typedef enum logic [1:0] {PH_LOW, PH_WAIT, PH_HIGH} burst_e;

    // Counts for one channel pair
    typedef struct packed {
        logic [25:0] high_res_count;
        logic [7:0] low_res_count;
    } burst_cfg_s;

    // Sample words toward the line encoder
    typedef struct packed {
        logic [15:0] word_i;
        logic [15:0] word_q;
        logic complex_fmt;
    } out_s;

endpackage

// file: core/dec2_stage.sv
`timescale 1ns/1ps
`default_nettype none
// Two-tap decimate-by-two, low-pass sum or high-pass difference
module dec2_stage #(
    parameter int W = 14
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic signed [W-1:0] in_data,
    input wire logic hp_sel,
    output logic out_valid,
    output logic signed [W-1:0] out_data
);
    logic signed [W-1:0] held; // First sample of pair
    logic odd; // Second sample of pair due
    wire logic signed [W:0] pair_sum = (W+1)'(held) + (W+1)'(in_data);
    wire logic signed [W:0] pair_dif = (W+1)'(in_data) - (W+1)'(held);
    wire logic signed [W:0] pair_res = hp_sel ? pair_dif : pair_sum;

    // Halve to keep unity gain
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            held <= '0;
            odd <= 1'b0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            out_valid <= in_valid && odd;
            if (in_valid) begin
                odd <= !odd;
                held <= in_data;
                if (odd) begin
                    out_data <= pair_res[W:1];
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: core/ddc_burst_output_control.sv
`timescale 1ns/1ps
`default_nettype none
module ddc_burst_output_control
    import ddc_burst_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sample_valid, // Converter sample strobe
    input wire logic signed [13:0] sample_data, // Converter sample
    input wire logic [7:0] coarse_code, // Early pipeline result
    input wire logic reg_wr_en, // Register write strobe
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire ddc_mode_e ddc_mode, // Shared decimation mode
    input wire logic stage1_hp, // First stage high-pass
    input wire logic stage2_hp, // Second stage high-pass, mode 2
    input wire logic fs4_negative, // Fixed mixer sign
    input wire logic [15:0] oscillator_tuning_word,
    input wire logic [1:0] burst_en, // Burst per pair, bit 1 is C/D
    input wire burst_cfg_s [1:0] burst_cfg,
    input wire logic [1:0] auto_trigger, // Auto per pair
    input wire logic trig_pin_sel, // 1 picks C/D pin
    input wire logic chan_pair, // This channel's pair
    input wire logic marker_embed,
    input wire logic fast_overrange_embed,
    input wire logic pair_ab_trigger_pin,
    input wire logic pair_cd_trigger_pin,
    output logic [7:0] reg_rdata,
    output out_s out_word,
    output logic out_valid,
    output logic [1:0] high_res_marker,
    output logic fast_overrange
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta, rst_s_n; // Two-stage release copy

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_s_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_s_n <= rst_meta;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_s_n);

    // ------------------------------------------------------------
    // Threshold registers and overrange
    // ------------------------------------------------------------
    logic [7:0] overrange_upper_threshold;
    logic [7:0] overrange_lower_threshold;
    wire logic hit_upper = reg_addr == UPPER_THR_OFFSET;
    wire logic hit_lower = reg_addr == LOWER_THR_OFFSET;
    // Unmapped addresses read zero
    wire logic [7:0] next_rdata = hit_upper ? overrange_upper_threshold :
                                  hit_lower ? overrange_lower_threshold : 8'h00;
    // 136 is top code, 8 bottom code, 72 midscale
    wire logic over_hi = coarse_code >= overrange_upper_threshold;
    wire logic over_lo = coarse_code <= overrange_lower_threshold;

    // Writes and the overrange compare
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            overrange_upper_threshold <= UPPER_THR_RESET;
            overrange_lower_threshold <= LOWER_THR_RESET;
            reg_rdata <= 8'h00;
            fast_overrange <= 1'b0;
        end else begin
            if (reg_wr_en && hit_upper) begin
                overrange_upper_threshold <= reg_wdata;
            end
            if (reg_wr_en && hit_lower) begin
                overrange_lower_threshold <= reg_wdata;
            end
            reg_rdata <= next_rdata;
            fast_overrange <= over_hi || over_lo;
        end
    end

    a_fast_overrange_upper_hit: assert property (over_hi |=> fast_overrange)
        else $error("overrange missed above upper threshold");
    a_fast_overrange_quiet: assert property (!over_hi && !over_lo |=> !fast_overrange)
        else $error("overrange raised inside thresholds");

    // ------------------------------------------------------------
    // First decimation stage, always in the path
    // ------------------------------------------------------------
    logic s1_valid;
    logic signed [13:0] s1_data;

    dec2_stage #(.W(14)) u_stage1 (
        .sys_clk(sys_clk),
        .rst_n(rst_s_n),
        .in_valid(sample_valid),
        .in_data(sample_data),
        .hp_sel(stage1_hp),
        .out_valid(s1_valid),
        .out_data(s1_data)
    );

    // ------------------------------------------------------------
    // Oscillator and mixers
    // ------------------------------------------------------------
    // Coarse 16-step sine, good enough for mixing by stepped phase
    function automatic logic signed [7:0] sine_lut(input logic [15:0] ph);
        logic [7:0] mag;
        unique case (ph[14:12])
            3'h0: mag = 8'h00;
            3'h1: mag = 8'h31;
            3'h2: mag = 8'h5a;
            3'h3: mag = 8'h75;
            3'h4: mag = 8'h7f;
            3'h5: mag = 8'h75;
            3'h6: mag = 8'h5a;
            3'h7: mag = 8'h31;
        endcase
        return ph[15] ? -mag : mag;
    endfunction

    // Real part of a quarter-rate rotation, step k of four
    function automatic logic signed [13:0] quarter_real(
        input logic signed [13:0] ri, input logic signed [13:0] rq, input logic [1:0] k);
        unique case (k)
            2'h0: return ri;
            2'h1: return -rq;
            2'h2: return -ri;
            2'h3: return rq;
        endcase
    endfunction

    logic [15:0] nco_phase; // Accumulates tuning word
    logic [1:0] quarter_step; // Quarter-rate step at stage-1 rate
    wire logic signed [7:0] cos_v = sine_lut(nco_phase + COS_OFFSET);
    wire logic signed [7:0] sin_v = sine_lut(nco_phase);
    wire logic signed [21:0] prod_c = s1_data * cos_v;
    wire logic signed [21:0] prod_s = s1_data * sin_v;
    wire logic fixed_mix = ddc_mode == MODE_FS4_IQ;
    wire logic signed [13:0] fq_pos = fs4_negative ? -s1_data : s1_data;
    wire logic signed [13:0] fix_i = quarter_step == 2'h0 ? s1_data :
                                     quarter_step == 2'h2 ? -s1_data : 14'sh0000;
    wire logic signed [13:0] fix_q = quarter_step == 2'h1 ? -fq_pos :
                                     quarter_step == 2'h3 ? fq_pos : 14'sh0000;
    wire logic signed [13:0] mix_i = fixed_mix ? fix_i
                                   : prod_c[LUT_SHIFT+13:LUT_SHIFT];
    wire logic signed [13:0] mix_q = fixed_mix ? fix_q : -prod_s[LUT_SHIFT+13:LUT_SHIFT];

    // Phase steps by the tuning word each stage-1 sample
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            nco_phase <= 16'h0000;
            quarter_step <= 2'h0;
        end else if (s1_valid) begin
            nco_phase <= nco_phase + oscillator_tuning_word;
            quarter_step <= quarter_step + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Second stage: two cascaded halves per I and Q
    // ------------------------------------------------------------
    wire logic mode2 = ddc_mode == MODE_REAL_DEC4;
    logic [1:0] a_valid, b_valid;
    logic signed [13:0] a_out [2];
    logic signed [13:0] b_out [2];
    wire logic signed [13:0] st2_in [2] = '{mode2 ? s1_data : mix_i, mix_q};

    generate
        for (genvar g = 0; g < 2; g++) begin : g_iq
            // First half: selectable type only in mode 2
            dec2_stage #(.W(14)) u_half_a (
                .sys_clk(sys_clk),
                .rst_n(rst_s_n),
                .in_valid(s1_valid),
                .in_data(st2_in[g]),
                .hp_sel(mode2 && stage2_hp),
                .out_valid(a_valid[g]),
                .out_data(a_out[g])
            );
            // Second half completes decimate-by-eight for mode 6
            dec2_stage #(.W(14)) u_half_b (
                .sys_clk(sys_clk),
                .rst_n(rst_s_n),
                .in_valid(a_valid[g]),
                .in_data(a_out[g]),
                .hp_sel(1'b0),
                .out_valid(b_valid[g]),
                .out_data(b_out[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Trigger synchroniser and filter
    // ------------------------------------------------------------
    logic [1:0] trig_s1, trig_s2, trig_s3; // Three-flop chains
    logic [1:0] trig_lvl, trig_lvl_d; // Agreed level and its delay
    wire logic [1:0] trig_rise = trig_lvl & ~trig_lvl_d;
    wire logic manual_trig = trig_pin_sel ? trig_rise[1] : trig_rise[0];

    // A change counts once the last two stages agree
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            trig_s1 <= 2'b00;
            trig_s2 <= 2'b00;
            trig_s3 <= 2'b00;
            trig_lvl <= 2'b00;
            trig_lvl_d <= 2'b00;
        end else begin
            trig_s1 <= {pair_cd_trigger_pin, pair_ab_trigger_pin};
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            trig_lvl <= (trig_s2 & trig_s3) | (trig_lvl & (trig_s2 | trig_s3));
            trig_lvl_d <= trig_lvl;
        end
    end

    // ------------------------------------------------------------
    // Burst sequencers, one per channel pair
    // ------------------------------------------------------------
    generate
        for (genvar p = 0; p < 2; p++) begin : g_pair
            burst_e st;
            logic [26:0] run_left; // Samples left in this run
            logic [26:0] high_len; // Latched at cycle start
            logic en_d; // Burst enable last cycle
            wire logic [27:0] hc3 = 28'(burst_cfg[p].high_res_count) * DUTY_RATIO;
            wire logic duty_ok = hc3 <= 28'(burst_cfg[p].low_res_count);
            wire logic [26:0] low_load = duty_ok ?
                {18'h00000, burst_cfg[p].low_res_count, 1'b0} : {18'h00000, LC_DEFAULT, 1'b0};
            wire logic [26:0] high_load = duty_ok ?
                {burst_cfg[p].high_res_count, 1'b0} : {HC_DEFAULT, 1'b0};
            wire logic last = run_left == 27'h0000001;

            // Low run, optional trigger wait, high run, then again
            always_ff @(posedge sys_clk or negedge rst_s_n) begin
                if (!rst_s_n) begin
                    st <= PH_LOW;
                    run_left <= 27'h0000001;
                    high_len <= 27'h0000002;
                    en_d <= 1'b0;
                end else begin
                    en_d <= burst_en[p];
                    if (!burst_en[p]) begin
                        st <= PH_LOW;
                        run_left <= low_load;
                        high_len <= high_load;
                    end else begin
                        unique case (st)
                            PH_LOW: begin
                                if (s1_valid && last && auto_trigger[p]) begin
                                    st <= PH_HIGH;
                                    run_left <= high_len;
                                end else if (s1_valid && last) begin
                                    st <= PH_WAIT;
                                end else if (s1_valid) begin
                                    run_left <= run_left - 27'h0000001;
                                end
                            end
                            PH_WAIT: begin
                                // Low data keeps flowing while held
                                if (manual_trig || auto_trigger[p]) begin
                                    st <= PH_HIGH;
                                    run_left <= high_len;
                                end
                            end
                            PH_HIGH: begin
                                if (s1_valid && last) begin
                                    // Counts written meanwhile apply here
                                    st <= PH_LOW;
                                    run_left <= low_load;
                                    high_len <= high_load;
                                end else if (s1_valid) begin
                                    run_left <= run_left - 27'h0000001;
                                end
                            end
                        endcase
                    end
                end
            end

            a_auto_no_wait: assert property (auto_trigger[p] && st == PH_WAIT |=> st == PH_HIGH)
                else $error("auto trigger pair held waiting");
            a_manual_hold: assert property (
                st == PH_WAIT && !manual_trig && !auto_trigger[p] && burst_en[p] |=> st == PH_WAIT)
                else $error("high run released without trigger");
            a_entry_low: assert property ($rose(burst_en[p]) |-> st == PH_LOW)
                else $error("burst entry not in low phase");
            a_high_len: assert property ($rose(st == PH_HIGH) |-> run_left == $past(high_len))
                else $error("high run length differs from latched count");
            a_duty_default: assert property (!burst_en[p] && !duty_ok |=> high_len == 27'h0000002)
                else $error("duty limit did not restore default high count");
        end
    endgenerate

    // ------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------
    wire logic burst_act = burst_en[chan_pair];
    wire logic marker = chan_pair ? g_pair[1].st == PH_HIGH : g_pair[0].st == PH_HIGH;
    wire logic quarter_tune = oscillator_tuning_word == QUARTER_POS ||
                              oscillator_tuning_word == QUARTER_NEG;
    wire logic invert = stage1_hp ^ stage2_hp;
    logic [1:0] out_k; // Output-rate quarter step
    logic zero_due; // Zero slot owed in mode 7
    logic next_valid, next_cplx;
    logic signed [13:0] next_i, next_q;
    wire logic mk_bit = marker_embed && burst_act && marker;
    wire logic [15:0] next_word_i = {next_i, mk_bit, fast_overrange_embed && fast_overrange};
    wire logic [15:0] next_word_q = {next_q, 1'b0, fast_overrange_embed && fast_overrange};
    wire logic [13:0] low_mask = ~14'((1 << LOW_RES_DROP) - 1);

    // Per-mode choice of sample and strobe
    always_comb begin
        next_valid = 1'b0;
        next_cplx = 1'b0;
        next_i = 14'sh0000;
        next_q = 14'sh0000;
        if (burst_act) begin
            next_valid = s1_valid;
            next_i = marker ? s1_data : (s1_data & low_mask);
        end else begin
            unique case (ddc_mode)
                MODE_FS4_IQ, MODE_NCO_IQ: begin
                    next_valid = a_valid[0];
                    next_cplx = 1'b1;
                    next_i = a_out[0];
                    next_q = a_out[1];
                end
                MODE_REAL_DEC4: begin
                    next_valid = a_valid[0];
                    next_i = (invert && out_k[0]) ? -a_out[0] : a_out[0];
                end
                MODE_NCO_REAL2: begin
                    next_valid = s1_valid;
                    next_i = quarter_tune ? 14'sh0000
                           : quarter_real(mix_i, mix_q, quarter_step);
                end
                MODE_NCO_REAL4: begin
                    next_valid = a_valid[0];
                    next_i = quarter_real(a_out[0], a_out[1], out_k);
                end
                MODE_NCO_DEC8: begin
                    next_valid = b_valid[0];
                    next_cplx = 1'b1;
                    next_i = b_out[0];
                    next_q = b_out[1];
                end
                MODE_ZERO_STUFF: begin
                    next_valid = a_valid[0] || (s1_valid && zero_due);
                    next_i = a_valid[0] ? quarter_real(a_out[0], a_out[1], out_k)
                           : 14'sh0000;
                end
                MODE_RESERVED: begin
                    next_valid = 1'b0;
                end
            endcase
        end
    end

    // Output words straight from flops
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            out_word <= '0;
            out_valid <= 1'b0;
            out_k <= 2'h0;
            zero_due <= 1'b0;
            high_res_marker <= 2'b00;
        end else begin
            out_valid <= next_valid;
            if (next_valid) begin
                out_word <= '{word_i: next_word_i, word_q: next_word_q, complex_fmt: next_cplx};
            end
            if (a_valid[0]) begin
                out_k <= out_k + 2'h1;
            end
            // New sample owes a zero; it wins over the clear
            if (a_valid[0] && ddc_mode == MODE_ZERO_STUFF) begin
                zero_due <= 1'b1;
            end else if (s1_valid) begin
                zero_due <= 1'b0;
            end
            high_res_marker <= {g_pair[1].st == PH_HIGH, g_pair[0].st == PH_HIGH};
        end
    end

    a_lowres_mask: assert property (
        burst_act && !marker && s1_valid |=> out_valid && out_word.word_i[6:2] == 5'h00)
        else $error("low resolution sample carries extra bits");
    a_mode3_zero: assert property (
        !burst_act && ddc_mode == MODE_NCO_REAL2 && quarter_tune && s1_valid
        |=> out_word.word_i[15:2] == 14'h0000)
        else $error("quarter-rate tuning did not zero the output");
endmodule
`default_nettype wire

// file: sim/link_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Transport side: takes every word, no back-pressure
// ------------------------------------------------
module link_sink
    import ddc_burst_pkg::*;
(
    input wire logic sys_clk,
    input wire out_s out_word,
    input wire logic out_valid,
    output logic [15:0] last_i, // Last real or I word
    output int n_words // Words taken so far
);
    initial n_words = 0;
    // Latch on each strobe; a strobe is seen once only
    always @(posedge sys_clk) begin
        if (out_valid) begin
            last_i <= out_word.word_i;
            n_words <= n_words + 1;
        end
    end
endmodule
`default_nettype wire

// file: sim/ddc_burst_output_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t mismatch", $time); end end
module ddc_burst_output_control_tb
    import ddc_burst_pkg::*;
;
    // ------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------
    logic sys_clk = 0, rst_n = 0, sample_valid = 1, reg_wr_en = 0, stage1_hp = 0, stage2_hp = 0;
    logic fs4_negative = 0, trig_pin_sel = 0, chan_pair = 0, marker_embed = 1, fast_overrange_embed = 1;
    logic pair_ab_trigger_pin = 0, pair_cd_trigger_pin = 0, out_valid, fast_overrange;
    logic signed [13:0] sample_data = 0;
    logic [7:0] coarse_code = 8'h48, reg_addr = 0, reg_wdata = 0, reg_rdata, q, upper = 8'h88;
    logic [15:0] oscillator_tuning_word = 16'h1000, last_i;
    logic [1:0] burst_en = 0, auto_trigger = 2'h3, high_res_marker;
    ddc_mode_e ddc_mode = MODE_FS4_IQ;
    burst_cfg_s [1:0] burst_cfg = '0;
    out_s out_word;
    logic [16:0] seed = 17'h135df; // Fixed seed, repeatable run
    int error_cnt = 0, checks_done = 0, cycles = 0, n_words, n0, hi, lo;
    int hcs[3] = '{1, 2, 2}, lcs[3] = '{3, 3, 8}; // Second pair exceeds the duty limit
    ddc_burst_output_control uut (.sys_clk, .rst_n, .sample_valid, .sample_data, .coarse_code,
        .reg_wr_en, .reg_addr, .reg_wdata, .ddc_mode, .stage1_hp, .stage2_hp, .fs4_negative,
        .oscillator_tuning_word, .burst_en, .burst_cfg, .auto_trigger, .trig_pin_sel, .chan_pair,
        .marker_embed, .fast_overrange_embed, .pair_ab_trigger_pin, .pair_cd_trigger_pin, .reg_rdata,
        .out_word, .out_valid, .high_res_marker, .fast_overrange);
    link_sink sink (.sys_clk, .out_word, .out_valid, .last_i, .n_words);
    // ------------------------------------------------
    // Clock, random samples, hang guard
    // ------------------------------------------------
    initial forever #12.5 sys_clk = ~sys_clk;
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    always @(negedge sys_clk) begin
        seed <= lfsr(seed);
        sample_data <= seed[13:0];
        stage1_hp <= seed[14];
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // Expected run length in clocks: stage-1 sample every 2 clocks
    function automatic int run_len(input int hc, input int lc, input bit high);
        if (3 * hc > lc) begin
            hc = HC_DEFAULT;
            lc = LC_DEFAULT;
        end
        return high ? 4 * hc : 4 * lc;
    endfunction
    // Output words per 64 clocks, from the stage rates of each mode
    function automatic int exp_words(input int m);
        case (m)
            3, 7: return 32;
            5: return 0;
            6: return 8;
            default: return 16;
        endcase
    endfunction
    function automatic logic ovr(input logic [7:0] c);
        return c >= upper || c <= LOWER_THR_RESET;
    endfunction
    // One register cycle; read data lands a clock later
    task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr_en = we;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr_en = 0;
        q = reg_rdata;
    endtask
    // Measure one high run then the following low run
    task automatic run();
        hi = 0;
        lo = 0;
        while (high_res_marker[0] !== 1'b1 && lo < 400) begin @(negedge sys_clk); lo++; end
        lo = 0;
        while (high_res_marker[0] === 1'b1 && hi < 400) begin @(negedge sys_clk); hi++; end
        while (high_res_marker[0] === 1'b0 && lo < 400) begin @(negedge sys_clk); lo++; end
    endtask
    task automatic end_of_test();
        $display("error_cnt %0d checks_done %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        repeat (10) @(negedge sys_clk);
        rst_n = 1;
        repeat (3) @(negedge sys_clk);
        acc(0, UPPER_THR_OFFSET, 0); `CHK(q, UPPER_THR_RESET)
        acc(0, LOWER_THR_OFFSET, 0); `CHK(q, LOWER_THR_RESET)
        acc(1, UPPER_THR_OFFSET, 8'h84); acc(0, UPPER_THR_OFFSET, 0); `CHK(q, 8'h84)
        acc(1, 8'h30, 8'h55); acc(0, 8'h30, 0); `CHK(q, 8'h00)
        upper = 8'h84;
        for (int i = 0; i < 40; i++) begin
            @(negedge sys_clk);
            coarse_code = (i < 4) ? 8'h83 + i[7:0] * 8'h3e : seed[16:9];
            @(negedge sys_clk);
            `CHK(fast_overrange, ovr(coarse_code))
        end
        // Idle pair holds counts over the duty limit, so defaults must load
        burst_cfg[0] = {26'h0000002, 8'h03};
        // Output cadence of every mode; mode 3 at quarter-rate tuning gives zeros
        for (int m = 0; m < 8; m++) begin
            ddc_mode = ddc_mode_e'(m);
            oscillator_tuning_word = (m == 3) ? QUARTER_POS : 16'h1000;
            repeat (16) @(negedge sys_clk);
            n0 = n_words;
            repeat (64) @(negedge sys_clk);
            `CHK(n_words - n0, exp_words(m))
            if (m == 3) `CHK(last_i[15:1], 15'h0000)
        end
        coarse_code = 8'hff;
        burst_en = 2'h1;
        foreach (hcs[i]) begin
            burst_cfg[0] = {hcs[i][25:0], lcs[i][7:0]};
            run();
            run();
            `CHK(hi, run_len(hcs[i], lcs[i], 1))
            `CHK(lo, run_len(hcs[i], lcs[i], 0))
        end
        `CHK(last_i[0], 1'b1)
        // Manual: wrong pin must not release the high run
        auto_trigger = 0;
        trig_pin_sel = 1;
        pair_ab_trigger_pin = 1;
        // Let the high run in progress finish before counting
        while (high_res_marker[0] === 1'b1) @(negedge sys_clk);
        hi = 0;
        repeat (60) begin @(negedge sys_clk); hi += high_res_marker[0]; end
        `CHK(hi, 0)
        pair_cd_trigger_pin = 1;
        lo = 0;
        while (high_res_marker[0] !== 1'b1 && lo < 20) begin @(negedge sys_clk); lo++; end
        `CHK(lo >= 3 && lo <= 7, 1'b1)
        // Park in the trigger wait, then switch to auto: high run must follow
        while (high_res_marker[0] === 1'b1) @(negedge sys_clk);
        repeat (40) @(negedge sys_clk);
        auto_trigger = 2'h3;
        repeat (3) @(negedge sys_clk);
        `CHK(high_res_marker[0], 1'b1)
        end_of_test();
    end
endmodule
`default_nettype wire
